// *** pkg/pixel_logic_pkg.sv ***
// Constants, types and helpers for the pixel logic, compare and stats block
package pixel_logic_pkg;

    localparam int         PIX_W          = 8;
    localparam int         DEF_CHANNELS   = 3;
    localparam int         DEF_MAX_PIXELS = 2073600;
    localparam logic [7:0] CMP_TRUE       = 8'hff;
    localparam logic [7:0] CMP_FALSE      = 8'h00;
    localparam logic [7:0] MASK_OFF       = 8'h00;
    localparam logic [2:0] SQRT_TOP       = 3'h7;

    typedef enum logic [2:0] {
        mode_and, mode_and_masked, mode_cmp_images,
        mode_cmp_scalar, mode_stats, mode_stats_masked
    } op_mode_t;

    typedef enum logic [2:0] {
        rel_equal, rel_greater, rel_greater_equal,
        rel_less, rel_less_equal, rel_not_equal
    } relation_t;

    typedef enum logic [2:0] {
        st_accumulate, st_launch_sum, st_wait_sum,
        st_launch_sq, st_wait_sq, st_root, st_finish
    } stats_state_t;

    function automatic logic rel_holds(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input relation_t  rel);
        case (rel)
            rel_equal:         return a == b;
            rel_greater:       return a > b;
            rel_greater_equal: return a >= b;
            rel_less:          return a < b;
            rel_less_equal:    return a <= b;
            rel_not_equal:     return a != b;
            default:           return 1'b0;
        endcase
    endfunction

    function automatic logic uses_mask(input op_mode_t m);
        return (m == mode_and_masked) || (m == mode_stats_masked);
    endfunction

    function automatic logic uses_second(input op_mode_t m);
        return (m == mode_and) || (m == mode_and_masked) ||
               (m == mode_cmp_images);
    endfunction

    function automatic logic is_stats(input op_mode_t m);
        return (m == mode_stats) || (m == mode_stats_masked);
    endfunction

endpackage

// *** test/result_sink.sv ***
// Downstream stage model: takes result pixels, stalls on request
`timescale 1ns/100ps
module result_sink #(
    parameter int W = 24
) (
    input  wire logic         sys_clk_i,  // Clock
    input  wire logic         resetn_i,   // Reset, active low
    input  wire logic         stall_i,    // Hold ready low next cycle
    input  wire logic         valid_i,    // Result valid
    output logic              ready_o,    // Result ready
    input  wire logic [W-1:0] data_i,     // Result pixel
    output logic              got_o,      // Pixel taken at last edge
    output logic [W-1:0]      got_data_o  // Pixel taken
);
    // Ready only changes away from the sampling edge
    always @(negedge sys_clk_i) begin
        ready_o <= resetn_i && !stall_i;
    end
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            got_o      <= 1'b0;
            got_data_o <= '0;
        end else begin
            got_o      <= valid_i && ready_o;
            got_data_o <= data_i;
        end
    end
endmodule

// *** test/tb.sv ***
// Self-checking bench for the pixel logic, compare and stats block
`timescale 1ns/100ps
module tb;
    import pixel_logic_pkg::*;
    logic clk, resetn, vld, last, stall, rdy, got;
    op_mode_t    mode;
    relation_t   rel;
    logic [7:0]  scal, mk;
    logic [23:0] da, db, df, got_d, res_d;
    logic        fr, sr, mr, br, res_v, busy, done;
    logic [23:0] mean, sdev;
    logic [15:0] lfsr = 16'h001e;
    logic [23:0] exp_q[$];
    logic [23:0] exp_d;
    int errors = 0;
    int checks_done = 0;
    int md, r;

    pixel_logic_compare_stats #(.CH(3), .MAX_PIXELS(64)) u_dut (
        .sys_clk_i(clk), .resetn_i(resetn), .mode_i(mode),
        .relation_select_i(rel), .scalar_value_i(scal),
        .first_image_valid_i(vld), .first_image_ready_o(fr),
        .first_image_data_i(da), .first_image_last_i(last),
        .second_image_valid_i(vld), .second_image_ready_o(sr),
        .second_image_data_i(db), .mask_valid_i(vld),
        .mask_ready_o(mr), .mask_data_i(mk), .fallback_valid_i(vld),
        .fallback_ready_o(br), .fallback_data_i(df),
        .result_valid_o(res_v), .result_ready_i(rdy),
        .result_data_o(res_d), .stats_busy_o(busy),
        .stats_done_o(done), .stats_mean_o(mean), .stats_sdev_o(sdev));
    result_sink #(.W(24)) u_sink (
        .sys_clk_i(clk), .resetn_i(resetn), .stall_i(stall),
        .valid_i(res_v), .ready_o(rdy), .data_i(res_d),
        .got_o(got), .got_data_o(got_d));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    function automatic logic holds(logic [7:0] a, logic [7:0] b);
        case (rel)
            rel_equal:         return a == b;
            rel_greater:       return a > b;
            rel_greater_equal: return a >= b;
            rel_less:          return a < b;
            rel_less_equal:    return a <= b;
            default:           return a != b;
        endcase
    endfunction
    function automatic logic [23:0] exp_px();
        logic [7:0] y;
        y = (mode == mode_cmp_scalar) ? scal : db[7:0];
        if (mode == mode_and) return da & db;
        if (mode == mode_and_masked) return (mk != 8'h00) ? da & db : df;
        return {16'h0000, holds(da[7:0], y) ? 8'hff : 8'h00};
    endfunction
    task automatic chk(input string what, input logic [47:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // One frame of n pixels in the current mode
    // ------------------------------------------------------------
    task automatic frame(input int n);
        int i, c, t, k, v, sd;
        int s[3], q[3];
        logic st, sel;
        logic [2:0] er;
        st = (mode == mode_stats) || (mode == mode_stats_masked);
        er = {mode == mode_and || mode == mode_and_masked ||
              mode == mode_cmp_images,
              mode == mode_and_masked || mode == mode_stats_masked,
              mode == mode_and_masked};
        k = 0;
        s = '{0, 0, 0};
        q = '{0, 0, 0};
        for (i = 0; i < n; i++) begin
            da = {rnd(), rnd(), rnd()};
            db = {rnd(), rnd(), (i == 0) ? da[7:0] : rnd()};
            df = {rnd(), rnd(), rnd()};
            if (i == 1) da[7:0] = scal;
            mk = (i == 0 || rnd() < 8'h80) ? (rnd() | 8'h01)
                                           : 8'h00;
            last = (i == n - 1);
            vld = 1'b1;
            sel = (mode != mode_stats_masked) || (mk != 8'h00);
            if (st && sel) begin
                k++;
                for (c = 0; c < 3; c++) begin
                    s[c] += da[c*8+:8];
                    q[c] += da[c*8+:8] * da[c*8+:8];
                end
            end
            if (!st) exp_q.push_back(exp_px());
            // Sample ready once the sink's ready has settled
            for (t = 0; t < 3000; t++) begin
                #1;
                if (fr === 1'b1) break;
                @(negedge clk);
            end
            if (t == 3000) begin
                chk("timeout", 1, 0);
                final_report();
            end
            chk("readies", {sr, mr, br}, er);
            @(posedge clk);
            @(negedge clk);
        end
        vld = 1'b0;
        last = 1'b0;
        if (st) begin
            chk("busy", busy, 1);
            for (t = 0; t < 3000 && done !== 1'b1; t++) @(negedge clk);
            chk("done", done, 1);
            for (c = 0; c < 3; c++) begin
                v = q[c] / k - (s[c] / k) * (s[c] / k);
                for (sd = 0; (sd + 1) * (sd + 1) <= v; sd++);
                chk("mean", mean[c*8+:8], s[c] / k);
                chk("sdev", sdev[c*8+:8], sd);
            end
            @(negedge clk);
        end
        for (t = 0; t < 300 && exp_q.size() > 0; t++) @(negedge clk);
        chk("drained", exp_q.size(), 0);
    endtask

    // ------------------------------------------------------------
    // Clock, stalls, result checking and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(negedge clk) stall <= (rnd() < 8'h50);
    always @(negedge clk) begin
        if (resetn && got && exp_q.size() == 0)
            chk("extra", 1, 0);
        else if (resetn && got) begin
            exp_d = exp_q.pop_front();
            chk("result", got_d, exp_d);
        end
    end
    initial begin
        {resetn, vld, last} = 3'h0;
        mode = mode_and;
        rel = rel_equal;
        {scal, mk} = '0;
        {da, db, df} = '0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        chk("idle", {res_v, busy, done}, 0);
        for (md = 0; md < 6; md++) begin
            for (r = 0; r < 6; r++) begin
                if (r == 0 || (md >= 2 && (md < 4 || r == 1))) begin
                    mode = op_mode_t'(md[2:0]);
                    rel = relation_t'(r[2:0]);
                    scal = rnd();
                    frame(md >= 4 ? 9 : 12);
                end
            end
        end
        final_report();
    end
endmodule

// *** verilog/pixel_logic_compare_stats.sv ***
// Pixel AND, compare and mean/deviation datapath on valid/ready streams
`timescale 1ns/100ps
module pixel_logic_compare_stats
    import pixel_logic_pkg::*;
#(
    parameter int CH         = DEF_CHANNELS,
    parameter int MAX_PIXELS = DEF_MAX_PIXELS
) (
    input  wire logic              sys_clk_i,            // Clock, 40 MHz
    input  wire logic              resetn_i,             // Async reset, low
    input  wire op_mode_t          mode_i,               // Operation
    input  wire relation_t         relation_select_i,    // Compare relation
    input  wire logic [7:0]        scalar_value_i,       // Scalar operand
    input  wire logic              first_image_valid_i,  // First valid
    output logic                   first_image_ready_o,  // First ready
    input  wire logic [CH*8-1:0]   first_image_data_i,   // First pixel
    input  wire logic              first_image_last_i,   // Last of frame
    input  wire logic              second_image_valid_i, // Second valid
    output logic                   second_image_ready_o, // Second ready
    input  wire logic [CH*8-1:0]   second_image_data_i,  // Second pixel
    input  wire logic              mask_valid_i,         // Mask valid
    output logic                   mask_ready_o,         // Mask ready
    input  wire logic [7:0]        mask_data_i,          // Mask byte
    input  wire logic              fallback_valid_i,     // Fallback valid
    output logic                   fallback_ready_o,     // Fallback ready
    input  wire logic [CH*8-1:0]   fallback_data_i,      // Fallback pixel
    output logic                   result_valid_o,       // Result valid
    input  wire logic              result_ready_i,       // Result ready
    output logic [CH*8-1:0]        result_data_o,        // Result pixel
    output logic                   stats_busy_o,         // Stats computing
    output logic                   stats_done_o,         // Stats ready pulse
    output logic [CH*8-1:0]        stats_mean_o,         // Mean per channel
    output logic [CH*8-1:0]        stats_sdev_o          // Deviation
);
    localparam int CNT_W = $clog2(MAX_PIXELS + 1);
    localparam int SUM_W = PIX_W + CNT_W;
    localparam int SQ_W  = 2 * PIX_W + CNT_W;
    localparam int DW    = CH * PIX_W;
    localparam int CH_W  = (CH > 1) ? $clog2(CH) : 1;
    localparam int PW    = 2 * SQ_W;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    stats_state_t st_reg, st_next;

    //--------------------------------------------------------------
    // Stream join
    //--------------------------------------------------------------
    logic need_second, need_mask, need_fb, stats_mode, go_ok;
    logic second_ok, mask_ok, fb_ok, fire, mask_sel;
    logic result_valid_reg, result_valid_next;
    logic [DW-1:0] result_data_reg, result_data_next;

    always_comb begin
        need_second = uses_second(mode_i);
        need_mask   = uses_mask(mode_i);
        need_fb     = (mode_i == mode_and_masked);
        stats_mode  = is_stats(mode_i);
        // Stats stall the sources until the frame's results are out
        go_ok     = stats_mode ? (st_reg == st_accumulate)
                               : (!result_valid_reg || result_ready_i);
        second_ok = !need_second || second_image_valid_i;
        mask_ok   = !need_mask || mask_valid_i;
        fb_ok     = !need_fb || fallback_valid_i;
        fire      = go_ok && first_image_valid_i && second_ok &&
                    mask_ok && fb_ok;
        mask_sel  = !need_mask || (mask_data_i != MASK_OFF);
    end

    // One pixel of each stream in use moves together
    assign first_image_ready_o  = go_ok && second_ok && mask_ok && fb_ok;
    assign second_image_ready_o = need_second && go_ok &&
                                  first_image_valid_i && mask_ok && fb_ok;
    assign mask_ready_o         = need_mask && go_ok &&
                                  first_image_valid_i && second_ok && fb_ok;
    assign fallback_ready_o     = need_fb && go_ok &&
                                  first_image_valid_i && second_ok && mask_ok;

    //--------------------------------------------------------------
    // Pixel operations
    //--------------------------------------------------------------
    logic [DW-1:0] and_pix, pix_calc;
    logic          cmp_hit;

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_and
            assign and_pix[g*PIX_W +: PIX_W] =
                first_image_data_i[g*PIX_W +: PIX_W] &
                second_image_data_i[g*PIX_W +: PIX_W];
        end
    endgenerate

    always_comb begin
        cmp_hit = rel_holds(first_image_data_i[PIX_W-1:0],
                            (mode_i == mode_cmp_scalar) ? scalar_value_i
                                : second_image_data_i[PIX_W-1:0],
                            relation_select_i);
        case (mode_i)
            mode_and:        pix_calc = and_pix;
            mode_and_masked: pix_calc = mask_sel ? and_pix
                                                 : fallback_data_i;
            mode_cmp_images,
            mode_cmp_scalar: pix_calc = DW'(cmp_hit ? CMP_TRUE
                                                    : CMP_FALSE);
            default:         pix_calc = '0;
        endcase
        result_valid_next = result_valid_reg;
        result_data_next  = result_data_reg;
        if (fire && !stats_mode) begin
            result_valid_next = 1'b1;
            result_data_next  = pix_calc;
        end else if (result_ready_i) begin
            result_valid_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            result_valid_reg <= 1'b0;
            result_data_reg  <= '0;
        end else begin
            result_valid_reg <= result_valid_next;
            result_data_reg  <= result_data_next;
        end
    end

    assign result_valid_o = result_valid_reg;
    assign result_data_o  = result_data_reg;

    and_result_a: assert property (fire && mode_i == mode_and |=>
        result_data_o == ($past(first_image_data_i) &
                          $past(second_image_data_i)))
        else $error("AND result differs from inputs");
    mask_fallback_a: assert property (fire && mode_i == mode_and_masked &&
        mask_data_i == MASK_OFF |=>
        result_data_o == $past(fallback_data_i))
        else $error("Masked-off pixel not taken from fallback");
    mask_consume_a: assert property (fire && mode_i == mode_and_masked |->
        mask_ready_o && fallback_ready_o && second_image_ready_o)
        else $error("Masked AND did not take mask and fallback");
    cmp_images_a: assert property (fire && mode_i == mode_cmp_images |=>
        result_valid_o && result_data_o[7:0] ==
        (rel_holds($past(first_image_data_i[7:0]),
                   $past(second_image_data_i[7:0]),
                   $past(relation_select_i)) ? 8'hff : 8'h00))
        else $error("Image compare result wrong");
    cmp_scalar_a: assert property (fire && mode_i == mode_cmp_scalar &&
        first_image_data_i[7:0] == scalar_value_i &&
        relation_select_i == rel_greater_equal |=>
        result_data_o[7:0] == 8'hff)
        else $error("Scalar compare missed an equal pixel");
    cmp_single_a: assert property (fire && (mode_i == mode_cmp_images ||
        mode_i == mode_cmp_scalar) |=>
        (result_data_o >> PIX_W) == '0)
        else $error("Compare result wider than one channel");
    hold_stall_a: assert property (result_valid_o && !result_ready_i |=>
        result_valid_o && $stable(result_data_o))
        else $error("Result dropped or changed under back-pressure");
    cover_masked_c: cover property (fire && mode_i == mode_and_masked);
    cover_cmp_c: cover property (fire && mode_i == mode_cmp_scalar);
    cover_stall_c: cover property (result_valid_o && !result_ready_i);

    //--------------------------------------------------------------
    // Statistics
    //--------------------------------------------------------------
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [SUM_W-1:0] sum_reg [CH];
    logic [SUM_W-1:0] sum_next [CH];
    logic [SQ_W-1:0]  sq_reg [CH];
    logic [SQ_W-1:0]  sq_next [CH];
    logic [CH_W-1:0]  ch_reg, ch_next;
    logic [DW-1:0]    mean_reg, mean_next, sdev_reg, sdev_next;
    logic [15:0]      var_reg, var_next;
    logic [7:0]       root_reg, root_next, trial;
    logic [2:0]       bit_reg, bit_next;
    logic             done_reg, done_next;
    logic             div_start, div_done;
    logic [SQ_W-1:0]  div_q, div_dividend;

    assign div_start    = (st_reg == st_launch_sum) ||
                          (st_reg == st_launch_sq);
    assign div_dividend = (st_reg == st_launch_sq) ? sq_reg[ch_reg]
                                                   : SQ_W'(sum_reg[ch_reg]);

    pixel_stats_divider #(
        .W          (SQ_W)
    ) u_divider (
        .sys_clk_i  (sys_clk_i),
        .resetn_i   (resetn_i),
        .start_i    (div_start),
        .dividend_i (div_dividend),
        .divisor_i  (SQ_W'(cnt_reg)),
        .done_o     (div_done),
        .quotient_o (div_q)
    );

    always_comb begin
        logic [15:0] px;
        logic [7:0]  m;
        px        = '0;
        m         = mean_reg[ch_reg*PIX_W +: PIX_W];
        st_next   = st_reg;
        ch_next   = ch_reg;
        cnt_next  = cnt_reg;
        sum_next  = sum_reg;
        sq_next   = sq_reg;
        mean_next = mean_reg;
        sdev_next = sdev_reg;
        var_next  = var_reg;
        root_next = root_reg;
        bit_next  = bit_reg;
        done_next = 1'b0;
        trial     = root_reg | (8'h01 << bit_reg);
        case (st_reg)
            st_accumulate: begin
                if (fire && stats_mode) begin
                    if (mask_sel) begin
                        cnt_next = cnt_reg + 1'b1;
                        for (int c = 0; c < CH; c++) begin
                            px = {8'h00, first_image_data_i[c*PIX_W +: PIX_W]};
                            sum_next[c] = sum_reg[c] + SUM_W'(px);
                            sq_next[c]  = sq_reg[c] + SQ_W'(px * px);
                        end
                    end
                    if (first_image_last_i) begin
                        st_next = st_launch_sum;
                        ch_next = '0;
                    end
                end
            end
            st_launch_sum: st_next = st_wait_sum;
            st_wait_sum: begin
                if (div_done) begin
                    mean_next[ch_reg*PIX_W +: PIX_W] = div_q[7:0];
                    st_next = st_launch_sq;
                end
            end
            st_launch_sq: st_next = st_wait_sq;
            st_wait_sq: begin
                if (div_done) begin
                    // Mean square minus squared mean, never negative
                    var_next  = div_q[15:0] - ({8'h00, m} * {8'h00, m});
                    root_next = '0;
                    bit_next  = SQRT_TOP;
                    st_next   = st_root;
                end
            end
            st_root: begin
                if ({8'h00, trial} * {8'h00, trial} <= var_reg) begin
                    root_next = trial;
                end
                bit_next = bit_reg - 1'b1;
                if (bit_reg == '0) begin
                    sdev_next[ch_reg*PIX_W +: PIX_W] = root_next;
                    if (ch_reg == CH_W'(CH - 1)) begin
                        st_next = st_finish;
                    end else begin
                        ch_next = ch_reg + 1'b1;
                        st_next = st_launch_sum;
                    end
                end
            end
            st_finish: begin
                done_next = 1'b1;
                cnt_next  = '0;
                for (int c = 0; c < CH; c++) begin
                    sum_next[c] = '0;
                    sq_next[c]  = '0;
                end
                st_next = st_accumulate;
            end
            default: st_next = st_accumulate;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg   <= st_accumulate;
            ch_reg   <= '0;
            cnt_reg  <= '0;
            mean_reg <= '0;
            sdev_reg <= '0;
            var_reg  <= '0;
            root_reg <= '0;
            bit_reg  <= '0;
            done_reg <= 1'b0;
            for (int c = 0; c < CH; c++) begin
                sum_reg[c] <= '0;
                sq_reg[c]  <= '0;
            end
        end else begin
            st_reg   <= st_next;
            ch_reg   <= ch_next;
            cnt_reg  <= cnt_next;
            mean_reg <= mean_next;
            sdev_reg <= sdev_next;
            var_reg  <= var_next;
            root_reg <= root_next;
            bit_reg  <= bit_next;
            done_reg <= done_next;
            sum_reg  <= sum_next;
            sq_reg   <= sq_next;
        end
    end

    assign stats_busy_o = (st_reg != st_accumulate);
    assign stats_done_o = done_reg;
    assign stats_mean_o = mean_reg;
    assign stats_sdev_o = sdev_reg;

    logic [PW-1:0] prod_lo, prod_hi;
    assign prod_lo = PW'(div_q) * PW'(cnt_reg);
    assign prod_hi = prod_lo + PW'(cnt_reg);

    mean_div_a: assert property (st_reg == st_wait_sum && div_done |->
        prod_lo <= PW'(sum_reg[ch_reg]) &&
        prod_hi > PW'(sum_reg[ch_reg]))
        else $error("Mean is not the floor of sum over count");
    root_exact_a: assert property (st_reg == st_root && bit_reg == '0 |->
        {8'h00, root_next} * {8'h00, root_next} <= var_reg &&
        17'({8'h00, root_next} + 16'h0001) *
        17'({8'h00, root_next} + 16'h0001) > 17'(var_reg))
        else $error("Deviation is not the integer root");
    busy_block_a: assert property (stats_busy_o && stats_mode |->
        !first_image_ready_o)
        else $error("Pixel taken while stats are computing");
    cover_done_c: cover property (stats_done_o);
endmodule

// *** verilog/pixel_stats_divider.sv ***
// Restoring unsigned divider, one quotient bit per clock
`timescale 1ns/100ps
module pixel_stats_divider
    import pixel_logic_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         sys_clk_i,   // System clock
    input  wire logic         resetn_i,    // Async reset, active low
    input  wire logic         start_i,     // Load dividend, one pulse
    input  wire logic [W-1:0] dividend_i,  // Dividend
    input  wire logic [W-1:0] divisor_i,   // Divisor, held while busy
    output logic              done_o,      // Quotient ready, one pulse
    output logic [W-1:0]      quotient_o   // Quotient
);
    localparam int CW = $clog2(W + 1);

    logic [W-1:0]  rem_reg, rem_next, quo_reg, quo_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic          busy_reg, busy_next, done_reg, done_next;
    logic [W:0]    shifted, diff;

    always_comb begin
        shifted   = {rem_reg, quo_reg[W-1]};
        diff      = shifted - {1'b0, divisor_i};
        rem_next  = rem_reg;
        quo_next  = quo_reg;
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (start_i) begin
            rem_next  = '0;
            quo_next  = dividend_i;
            cnt_next  = CW'(W);
            busy_next = 1'b1;
        end else if (busy_reg) begin
            rem_next = diff[W] ? shifted[W-1:0] : diff[W-1:0];
            quo_next = {quo_reg[W-2:0], ~diff[W]};
            cnt_next = cnt_reg - 1'b1;
            if (cnt_reg == CW'(1)) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rem_reg  <= '0;
            quo_reg  <= '0;
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            rem_reg  <= rem_next;
            quo_reg  <= quo_next;
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign done_o     = done_reg;
    assign quotient_o = quo_reg;
endmodule
